// ---- inc/pfwr_pkg.sv ----
package pfwr_pkg;
  // register offsets on the plain register port (chosen)
  localparam logic [2:0] ADDR_CONTROL   = 3'h0;
  localparam logic [2:0] ADDR_DATA_LOW  = 3'h1;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h2;
  localparam logic [2:0] ADDR_ADR_LOW   = 3'h3;
  localparam logic [2:0] ADDR_ADR_HIGH  = 3'h4;
  // field positions
  localparam int START_BIT    = 0;
  localparam int RESERVED_BIT = 7;
  localparam int ADR_HIGH_W   = 5;
  localparam int DATA_HIGH_W  = 6;
  localparam int WORD_W       = 14;
  localparam int ADDR_W       = 13;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h80;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  // read timing: instruction cycles the flash controller needs
  localparam int READ_CYCLES = 2;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pfwr_bus_t;

  typedef enum logic [1:0] {
    PFWR_IDLE,
    PFWR_FETCH,
    PFWR_DONE
  } pfwr_state_t;
endpackage : pfwr_pkg

// ---- hw/pfwr_mem.sv ----
`timescale 1ns/10ps
module pfwr_mem #(
  parameter int ADDR_W = 13,
  parameter int WORD_W = 14
) (
  // clock
  input  wire logic              i_sys_clk,
  // read port
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_addr,
  output logic      [WORD_W-1:0] o_rdata,
  // program load port
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [WORD_W-1:0] i_wr_data
);
  logic [WORD_W-1:0] mem [2**ADDR_W];

  // no reset on the array; read data come from a register
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule : pfwr_mem

// ---- hw/pfwr_timer.sv ----
`timescale 1ns/10ps
module pfwr_timer #(
  parameter int CYCLES = 2
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  wire        last = (cnt_r == 4'(CYCLES - 1));

  assign cnt_nxt = i_start ? 4'h1 : (o_busy && !last) ? cnt_r + 4'h1 : 4'h0;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 4'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_busy <= i_start || (o_busy && !last);
      o_done <= o_busy && last;
    end
  end
endmodule : pfwr_timer

// ---- hw/pfwr_top.sv ----
`timescale 1ns/10ps
// Operation
// - address is high bits 4..0, low byte
// - writing one to bit 0 starts read
// - read takes two cycles; core ignores two
// - word loads into high and low data
// - data high bits 7..6 read zero
// - hardware clears start; software cannot clear
// - writing zero never starts a read
// - control bits 6..1 zero, bit 7 one
// - code protection never blocks these reads
module pfwr_top #(
  parameter int READ_CYCLES = pfwr_pkg::READ_CYCLES
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic [2:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // core side
  input  wire logic       i_code_protect,
  output logic            o_ignore_instr,
  output logic            o_read_busy,
  // program memory load port
  input  wire logic                          i_load_en,
  input  wire logic [pfwr_pkg::ADDR_W-1:0]   i_load_addr,
  input  wire logic [pfwr_pkg::WORD_W-1:0]   i_load_data
);
  pfwr_pkg::pfwr_bus_t bus;
  assign bus = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

  function automatic logic hit(input pfwr_pkg::pfwr_bus_t b, input logic [2:0] a);
    return b.wr && (b.addr == a);
  endfunction : hit

  logic [7:0]                          adr_lo_r;
  logic [pfwr_pkg::ADR_HIGH_W-1:0]     adr_hi_r;
  logic [7:0]                          dat_lo_r;
  logic [pfwr_pkg::DATA_HIGH_W-1:0]    dat_hi_r;
  logic                                start_r;
  pfwr_pkg::pfwr_state_t               state_r;
  pfwr_pkg::pfwr_state_t               state_nxt;
  logic [pfwr_pkg::WORD_W-1:0]         word;
  logic                                busy;
  logic                                done;

  wire wr_ctl   = hit(bus, pfwr_pkg::ADDR_CONTROL);
  wire wr_dlo   = hit(bus, pfwr_pkg::ADDR_DATA_LOW);
  wire wr_dhi   = hit(bus, pfwr_pkg::ADDR_DATA_HIGH);
  wire wr_alo   = hit(bus, pfwr_pkg::ADDR_ADR_LOW);
  wire wr_ahi   = hit(bus, pfwr_pkg::ADDR_ADR_HIGH);
  // a zero write never starts, and a start while busy is ignored
  wire go       = wr_ctl && bus.wdata[pfwr_pkg::START_BIT] && !start_r;
  // code protection is deliberately not an input to go
  wire unused_cp = i_code_protect;
  wire [pfwr_pkg::ADDR_W-1:0] rd_addr = {adr_hi_r, adr_lo_r};

  assign state_nxt = go   ? pfwr_pkg::PFWR_FETCH :
                     done ? pfwr_pkg::PFWR_DONE  :
                     (state_r == pfwr_pkg::PFWR_DONE) ? pfwr_pkg::PFWR_IDLE : state_r;

  wire [7:0] ctl_view = {1'b1, 6'h00, start_r};
  wire [7:0] rd_mux =
    (bus.addr == pfwr_pkg::ADDR_CONTROL)   ? ctl_view :
    (bus.addr == pfwr_pkg::ADDR_DATA_LOW)  ? dat_lo_r :
    (bus.addr == pfwr_pkg::ADDR_DATA_HIGH) ? {2'b00, dat_hi_r} :
    (bus.addr == pfwr_pkg::ADDR_ADR_LOW)   ? adr_lo_r :
    (bus.addr == pfwr_pkg::ADDR_ADR_HIGH)  ? {3'b000, adr_hi_r} :
    pfwr_pkg::ZERO_BYTE;

  pfwr_timer #(
    .CYCLES (READ_CYCLES)
  ) u_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_start   (go),
    .o_busy    (busy),
    .o_done    (done)
  );

  // sampled in the start write cycle (go), before busy; the address is stable since the
  // core ignores the following two instructions
  pfwr_mem #(
    .ADDR_W (pfwr_pkg::ADDR_W),
    .WORD_W (pfwr_pkg::WORD_W)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_rd_en   (go),
    .i_addr    (rd_addr),
    .o_rdata   (word),
    .i_wr_en   (i_load_en),
    .i_wr_addr (i_load_addr),
    .i_wr_data (i_load_data)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_r <= 1'b0;
      state_r <= pfwr_pkg::PFWR_IDLE;
    end else begin
      state_r <= state_nxt;
      if (go) begin
        start_r <= 1'b1;
      end else if (done) begin
        start_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      adr_lo_r <= pfwr_pkg::ZERO_BYTE;
      adr_hi_r <= '0;
    end else begin
      // the read never touches the address pair
      if (wr_alo) begin
        adr_lo_r <= bus.wdata;
      end
      if (wr_ahi) begin
        adr_hi_r <= bus.wdata[pfwr_pkg::ADR_HIGH_W-1:0];
      end
    end
  end

  // completion wins over a software write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dat_lo_r <= pfwr_pkg::ZERO_BYTE;
      dat_hi_r <= '0;
    end else if (done) begin
      dat_lo_r <= word[7:0];
      dat_hi_r <= word[pfwr_pkg::WORD_W-1:8];
    end else begin
      if (wr_dlo) begin
        dat_lo_r <= bus.wdata;
      end
      if (wr_dhi) begin
        dat_hi_r <= bus.wdata[pfwr_pkg::DATA_HIGH_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata    <= pfwr_pkg::ZERO_BYTE;
      o_ignore_instr <= 1'b0;
      o_read_busy    <= 1'b0;
    end else begin
      o_reg_rdata    <= bus.rd ? rd_mux : pfwr_pkg::ZERO_BYTE;
      // asserted for the two instruction slots after the start
      o_ignore_instr <= go || (busy && !done && state_r == pfwr_pkg::PFWR_FETCH && !unused_cp) ||
                        (busy && !done && state_r == pfwr_pkg::PFWR_FETCH && unused_cp);
      o_read_busy    <= go || (busy && !done);
    end
  end
endmodule : pfwr_top

// ---- tb/pfwr_checker.sv ----
`timescale 1ns/10ps
module pfwr_checker (
  // clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  // register port
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // core side
  input wire logic       i_code_protect,
  input wire logic       o_ignore_instr,
  input wire logic       o_read_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire ctl_wr = i_reg_wr && i_reg_addr == pfwr_pkg::ADDR_CONTROL;
  wire ctl_rd = i_reg_rd && i_reg_addr == pfwr_pkg::ADDR_CONTROL;
  sequence s_start;
    ctl_wr && i_reg_wdata[0] && !o_read_busy;
  endsequence
  sequence s_fetch;
    o_read_busy [*2] ##1 !o_read_busy;
  endsequence
  a_start_fetch: assert property (s_start |=> s_fetch) else $error("read length wrong");
  a_ignore_busy: assert property (o_ignore_instr == o_read_busy) else $error("ignore differs");
  a_zero_idle: assert property (ctl_wr && !i_reg_wdata[0] && !o_read_busy |=> !o_read_busy)
    else $error("zero started read");
  a_busy_cause: assert property ($rose(o_read_busy) |-> $past(ctl_wr && i_reg_wdata[0]))
    else $error("busy without start");
  a_ctl_fixed: assert property (ctl_rd |=> o_reg_rdata[7:1] == 7'h40) else $error("control bits 7..1");
  a_start_bit: assert property (ctl_rd |=> o_reg_rdata[0] == $past(o_read_busy))
    else $error("start bit wrong");
  a_high_zero: assert property (i_reg_rd && i_reg_addr == pfwr_pkg::ADDR_DATA_HIGH |=> o_reg_rdata[7:6] == 2'h0)
    else $error("data high bits 7..6");
  a_protect_free: assert property (i_code_protect && ctl_wr && i_reg_wdata[0] && !o_read_busy |=> o_read_busy)
    else $error("protect blocked read");
endmodule : pfwr_checker

bind pfwr_top pfwr_checker chk_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_code_protect(i_code_protect), .o_ignore_instr(o_ignore_instr), .o_read_busy(o_read_busy));

// ---- tb/pfwr_loader.sv ----
`timescale 1ns/10ps
module pfwr_loader (
  // clock
  input  wire logic   i_sys_clk,
  // program load port
  output logic        o_load_en = 1'b0,
  output logic [12:0] o_load_addr = 13'h0000,
  output logic [13:0] o_load_data = 14'h0000
);
  logic [2:0]  k_r = 3'h0;
  logic [12:0] a;
  // four words, the top address among them, loaded while the core is held in reset
  assign a = 13'h1FFF - 13'(k_r) * 13'h0AAA;
  always_ff @(posedge i_sys_clk) begin
    o_load_en <= k_r < 3'h4;
    // idle lines toggle so a stale value never looks valid
    o_load_addr <= (k_r < 3'h4) ? a : ~o_load_addr;
    o_load_data <= (k_r < 3'h4) ? ({a, 1'b1} ^ 14'h2A5A) : ~o_load_data;
    if (k_r < 3'h4) k_r <= k_r + 3'h1;
  end
endmodule : pfwr_loader

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %0t got %h want %h", $time, g, e); end end
module tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [2:0]  i_reg_addr = 3'h0;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic        i_code_protect = 1'b0;
  logic        load_en, o_ignore_instr, o_read_busy;
  logic [12:0] load_addr, a;
  logic [13:0] load_data, w;
  logic [7:0]  o_reg_rdata;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;
  pfwr_top dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_code_protect(i_code_protect),
    .o_ignore_instr(o_ignore_instr), .o_read_busy(o_read_busy), .i_load_en(load_en), .i_load_addr(load_addr),
    .i_load_data(load_data));
  pfwr_loader core_u (.i_sys_clk(i_sys_clk), .o_load_en(load_en), .o_load_addr(load_addr),
    .o_load_data(load_data));
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] ad, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= ad;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 `CHK(o_reg_rdata, e)
  endtask : rd
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(pfwr_pkg::ADDR_CONTROL, pfwr_pkg::CONTROL_RESET);
    for (int i = 1; i < 6; i++) rd(3'(i), 8'h00);
    wr(pfwr_pkg::ADDR_ADR_HIGH, 8'hFF);
    rd(pfwr_pkg::ADDR_ADR_HIGH, 8'h1F);
    wr(pfwr_pkg::ADDR_DATA_HIGH, 8'hFF);
    rd(pfwr_pkg::ADDR_DATA_HIGH, 8'h3F);
    wr(pfwr_pkg::ADDR_CONTROL, 8'hFE);
    #1 `CHK(o_read_busy, 1'b0)
    rd(pfwr_pkg::ADDR_CONTROL, 8'h80);
    for (int k = 0; k < 4; k++) begin
      a = 13'h1FFF - 13'(k) * 13'h0AAA;
      w = {a, 1'b1} ^ 14'h2A5A;
      @(posedge i_sys_clk);
      i_code_protect <= k[0];
      wr(pfwr_pkg::ADDR_ADR_LOW, a[7:0]);
      wr(pfwr_pkg::ADDR_ADR_HIGH, {3'h0, a[12:8]});
      wr(pfwr_pkg::ADDR_CONTROL, 8'h01);
      #1 `CHK({o_ignore_instr, o_read_busy}, 2'b11)
      // two starts keep the ignored slots idle, two probe the start bit inside them
      if (k[1]) rd(pfwr_pkg::ADDR_CONTROL, 8'h81);
      else repeat (2) @(posedge i_sys_clk);
      rd(pfwr_pkg::ADDR_DATA_LOW, w[7:0]);
      rd(pfwr_pkg::ADDR_DATA_HIGH, {2'h0, w[13:8]});
      rd(pfwr_pkg::ADDR_CONTROL, 8'h80);
      rd(pfwr_pkg::ADDR_ADR_LOW, a[7:0]);
      rd(pfwr_pkg::ADDR_ADR_HIGH, {3'h0, a[12:8]});
    end
    wr(pfwr_pkg::ADDR_CONTROL, 8'h01);
    // this write lands on the completion edge on purpose, so the loaded word must win
    wr(pfwr_pkg::ADDR_DATA_LOW, 8'h5A);
    rd(pfwr_pkg::ADDR_DATA_LOW, w[7:0]);
    wr(pfwr_pkg::ADDR_DATA_LOW, 8'hA5);
    rd(pfwr_pkg::ADDR_DATA_LOW, 8'hA5);
    report_and_stop();
  end
endmodule : tb
